// >>> inc/smb_if.sv
// two-wire bus joining the master end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface smb_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // open-drain wired and with pull-ups
   assign scl = !(scl_m_oe && !scl_m_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport master (
      output scl_m_o,
      output scl_m_oe,
      output sda_m_o,
      output sda_m_oe,
      input  scl,
      input  sda
   );
   modport slave (
      output sda_s_o,
      output sda_s_oe,
      input  scl,
      input  sda
   );
endinterface : smb_if
`default_nettype wire

// >>> inc/smb_pkg.sv
// shared constants and types for the serial register-access link
package smb_pkg;
   // --------------------------------------------------------------------
   // slave addresses
   // --------------------------------------------------------------------
   localparam logic [6:0] ADDR_PIN_HIGH  = 7'h2f;
   localparam logic [6:0] ADDR_PIN_LOW   = 7'h2c;
   localparam logic [6:0] ADDR_PIN_FLOAT = 7'h2e;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   // --------------------------------------------------------------------
   // select pin codes
   // --------------------------------------------------------------------
   localparam logic [1:0] SEL_LOW   = 2'h0;
   localparam logic [1:0] SEL_HIGH  = 2'h1;
   localparam logic [1:0] SEL_FLOAT = 2'h2;
   // --------------------------------------------------------------------
   // framing and registers
   // --------------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] CFG1_ADDR     = 8'h40;
   localparam int         TOUT_BIT      = 3;
   localparam logic [7:0] CFG1_RESET    = 8'h00;
   localparam int         NUM_EVENTS    = 8;
   // --------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------
   localparam int CLK_MHZ         = 200;
   localparam int TIMEOUT_MS      = 31;
   localparam int TIMEOUT_CYCLES  = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int SCL_KHZ         = 400;
   localparam int SCL_HALF_CYCLES = CLK_MHZ * 1000 / SCL_KHZ / 2;
   // --------------------------------------------------------------------
   // device phases
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      SL_IDLE  = 3'b000,
      SL_ADDR  = 3'b001,
      SL_AACK  = 3'b010,
      SL_WRX   = 3'b011,
      SL_WACK  = 3'b100,
      SL_RTX   = 3'b101,
      SL_RACK  = 3'b110
   } smb_sl_state_t;
   typedef enum logic [3:0] {
      MS_IDLE  = 4'b0000,
      MS_START = 4'b0001,
      MS_BIT   = 4'b0010,
      MS_ACK   = 4'b0011,
      MS_STOP  = 4'b0100,
      MS_RSTA  = 4'b0101,
      MS_DONE  = 4'b0110
   } smb_ms_state_t;
endpackage : smb_pkg

// >>> src/smb_master.sv
// master end: issues write and read byte operations
`timescale 1ns/1ps
`default_nettype none
module smb_master (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   smb_if.master           bus,
   input  wire logic       req_i,
   input  wire logic [6:0] dev_addr_i,
   input  wire logic       read_i,
   input  wire logic [1:0] nbytes_i,
   input  wire logic [7:0] byte0_i,
   input  wire logic [7:0] byte1_i,
   input  wire logic       rstart_i,
   output logic            busy_o,
   output logic            done_o,
   output logic            nack_o,
   output logic [7:0]      rdata_o
);
   // --------------------------------------------------------------------
   // sync and sequencer
   // --------------------------------------------------------------------
   logic [1:0] sda_sync_reg;
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
         sda_sync_reg <= 2'h3;
      else if (ce_i)
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
   smb_pkg::smb_ms_state_t state_reg;
   logic [7:0] cnt_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic [1:0] idx_reg;
   logic       scl_reg;
   logic       sda_reg;
   logic       rd_reg;
   logic       rs_reg;
   logic       tick;
   assign tick = cnt_reg == 8'(smb_pkg::SCL_HALF_CYCLES / 2 - 1);
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
      begin
         state_reg <= smb_pkg::MS_IDLE;
         cnt_reg   <= 8'h00;
         phase_reg <= 2'h0;
         bit_reg   <= 4'h0;
         sh_reg    <= 8'h00;
         idx_reg   <= 2'h0;
         scl_reg   <= 1'b1;
         sda_reg   <= 1'b1;
         rd_reg    <= 1'b0;
         rs_reg    <= 1'b0;
         done_o    <= 1'b0;
         nack_o    <= 1'b0;
         rdata_o   <= 8'h00;
      end
      else if (ce_i)
      begin
         done_o  <= 1'b0;
         cnt_reg <= tick ? 8'h00 : cnt_reg + 8'h01;
         unique case (state_reg)
            smb_pkg::MS_IDLE:
               if (req_i)
               begin
                  state_reg <= smb_pkg::MS_START;
                  phase_reg <= 2'h0;
                  cnt_reg   <= 8'h00;
                  sh_reg    <= {dev_addr_i, 1'b0};
                  rd_reg    <= read_i && !rstart_i;
                  rs_reg    <= rstart_i;
                  idx_reg   <= 2'h0;
                  nack_o    <= 1'b0;
                  if (!rstart_i && read_i)
                     sh_reg <= {dev_addr_i, 1'b1};
               end
            smb_pkg::MS_START:
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  unique case (phase_reg)
                     2'h0: sda_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b0;
                     default:
                     begin
                        scl_reg   <= 1'b0;
                        bit_reg   <= 4'h0;
                        state_reg <= smb_pkg::MS_BIT;
                     end
                  endcase
               end
            smb_pkg::MS_BIT, smb_pkg::MS_ACK:
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  unique case (phase_reg)
                     2'h0:
                        if (state_reg == smb_pkg::MS_BIT)
                           sda_reg <= (idx_reg != 2'h0 && rd_reg) ? 1'b1 : sh_reg[7];
                        else
                           sda_reg <= 1'b1;
                     2'h1: scl_reg <= 1'b1;
                     2'h2:
                        if (state_reg == smb_pkg::MS_BIT)
                           sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                        else if (!(idx_reg != 2'h0 && rd_reg) && sda_sync_reg[1])
                           nack_o <= 1'b1;
                     default:
                     begin
                        scl_reg <= 1'b0;
                        if (state_reg == smb_pkg::MS_BIT)
                        begin
                           bit_reg <= bit_reg + 4'h1;
                           if (bit_reg == smb_pkg::BITS_PER_BYTE - 4'h1)
                              state_reg <= smb_pkg::MS_ACK;
                        end
                        else
                        begin
                           bit_reg <= 4'h0;
                           idx_reg <= idx_reg + 2'h1;
                           if (idx_reg != 2'h0 && rd_reg)
                              rdata_o <= sh_reg;
                           if (nack_o || (rd_reg && idx_reg != 2'h0) ||
                               (!rd_reg && idx_reg == nbytes_i))
                              state_reg <= (rs_reg && !nack_o) ? smb_pkg::MS_RSTA
                                                               : smb_pkg::MS_STOP;
                           else
                           begin
                              state_reg <= smb_pkg::MS_BIT;
                              sh_reg    <= (idx_reg == 2'h0) ? byte0_i : byte1_i;
                           end
                        end
                     end
                  endcase
               end
            smb_pkg::MS_RSTA:
            begin
               // pointer written, now read with repeated start
               state_reg <= smb_pkg::MS_START;
               phase_reg <= 2'h0;
               rs_reg    <= 1'b0;
               rd_reg    <= 1'b1;
               idx_reg   <= 2'h0;
               sh_reg    <= {dev_addr_i, 1'b1};
            end
            smb_pkg::MS_STOP:
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'h1;
                  unique case (phase_reg)
                     2'h0: sda_reg <= 1'b0;
                     2'h1: scl_reg <= 1'b1;
                     2'h2: sda_reg <= 1'b1;
                     default: state_reg <= smb_pkg::MS_DONE;
                  endcase
               end
            default:
            begin
               done_o    <= 1'b1;
               state_reg <= smb_pkg::MS_IDLE;
            end
         endcase
      end
   assign busy_o       = state_reg != smb_pkg::MS_IDLE;
   assign bus.scl_m_o  = 1'b0;
   assign bus.scl_m_oe = !scl_reg;
   assign bus.sda_m_o  = 1'b0;
   assign bus.sda_m_oe = !sda_reg;
endmodule : smb_master
`default_nettype wire

// >>> src/smb_slave.sv
// slave end: bus decode, pointer, register file, alert and timeout
//
// Behaviour
// - masked events set status, never pull alert
// - address picked from three-state select pin
// - select pin latched on first start condition
// - start detected, then eight bits msb first
// - acknowledge own address before ninth clock
// - direction bit picks write or read
// - nine pulses per byte, sda changes scl low
// - master ends read with nack then stop
// - direction fixed until new start
// - writes one or two bytes, reads one
// - first write byte loads the pointer
// - second write byte stored at pointer
// - pointer-only write changes no data
// - read returns pointed register, pointer kept
// - send, receive and combined read byte
// - repeated start treated as fresh start
// - works with serial clock to 400 kHz
// - alert low while any unmasked status set
// - timeout releases bus unless disabled
// - answer alert response address with own address
`timescale 1ns/1ps
`default_nettype none
module smb_slave #(
   parameter int TIMEOUT_CYC = smb_pkg::TIMEOUT_CYCLES
) (
   input  wire logic                            mclk_i,
   input  wire logic                            rst_i,
   input  wire logic                            ce_i,
   smb_if.slave                                 bus,
   input  wire logic [1:0]                      addr_sel_i,
   input  wire logic [smb_pkg::NUM_EVENTS-1:0]  event_i,
   input  wire logic [smb_pkg::NUM_EVENTS-1:0]  event_mask_i,
   input  wire logic                            status_clr_i,
   output logic [smb_pkg::NUM_EVENTS-1:0]       status_o,
   output logic                                 alert_n_o,
   output logic [7:0]                           pointer_o,
   output logic [7:0]                           cfg1_o
);
   // --------------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------------
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_sync_reg <= {scl_sync_reg[0], bus.scl};
         sda_sync_reg <= {sda_sync_reg[0], bus.sda};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_s     = scl_sync_reg[1];
   assign sda_s     = sda_sync_reg[1];
   assign scl_rise  = scl_s && !scl_d_reg;
   assign scl_fall  = !scl_s && scl_d_reg;
   assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   // --------------------------------------------------------------------
   // address latch
   // --------------------------------------------------------------------
   logic [6:0] own_addr_reg;
   logic       addr_latched_reg;
   logic [6:0] sel_addr;
   always_comb
      unique case (addr_sel_i)
         smb_pkg::SEL_HIGH:  sel_addr = smb_pkg::ADDR_PIN_HIGH;
         smb_pkg::SEL_FLOAT: sel_addr = smb_pkg::ADDR_PIN_FLOAT;
         default:            sel_addr = smb_pkg::ADDR_PIN_LOW;
      endcase
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
      begin
         own_addr_reg     <= 7'h00;
         addr_latched_reg <= 1'b0;
      end
      else if (ce_i && start_det && !addr_latched_reg)
      begin
         own_addr_reg     <= sel_addr;
         addr_latched_reg <= 1'b1;
      end
   logic [6:0] cur_addr;
   assign cur_addr = addr_latched_reg ? own_addr_reg : sel_addr;
   // --------------------------------------------------------------------
   // status and alert
   // --------------------------------------------------------------------
   logic [smb_pkg::NUM_EVENTS-1:0] status_reg;
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
         status_reg <= '0;
      else if (ce_i)
         status_reg <= (status_clr_i ? '0 : status_reg) | event_i;
   logic alert_act;
   assign alert_act = |(status_reg & ~event_mask_i);
   assign alert_n_o = !alert_act;
   assign status_o  = status_reg;
   // --------------------------------------------------------------------
   // byte engine
   // --------------------------------------------------------------------
   smb_pkg::smb_sl_state_t state_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic       rd_reg;
   logic       ara_reg;
   logic [1:0] wbyte_reg;
   logic [7:0] ptr_reg;
   logic [7:0] cfg1_reg;
   logic [7:0] regs_mem [0:255];
   logic       sda_oe_reg;
   logic [31:0] idle_cnt_reg;
   logic       tout;
   logic [7:0] rd_data;
   assign tout = !cfg1_reg[smb_pkg::TOUT_BIT] && (idle_cnt_reg > TIMEOUT_CYC);
   assign rd_data = ara_reg ? {cur_addr, 1'b1} :
                    (ptr_reg == smb_pkg::CFG1_ADDR) ? cfg1_reg : regs_mem[ptr_reg];
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
         idle_cnt_reg <= 32'h0;
      else if (ce_i)
      begin
         if (state_reg == smb_pkg::SL_IDLE || scl_rise || scl_fall)
            idle_cnt_reg <= 32'h0;
         else if (!tout)
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
      begin
         state_reg   <= smb_pkg::SL_IDLE;
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 4'h0;
         rd_reg      <= 1'b0;
         ara_reg     <= 1'b0;
         wbyte_reg   <= 2'h0;
         ptr_reg     <= 8'h00;
         cfg1_reg    <= smb_pkg::CFG1_RESET;
         sda_oe_reg  <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start_det)
         begin
            state_reg   <= smb_pkg::SL_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end
         else if (stop_det || tout)
         begin
            state_reg  <= smb_pkg::SL_IDLE;
            sda_oe_reg <= 1'b0;
         end
         else
            unique case (state_reg)
               smb_pkg::SL_IDLE:
                  sda_oe_reg <= 1'b0;
               smb_pkg::SL_ADDR:
                  if (scl_rise)
                  begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_reg == smb_pkg::BITS_PER_BYTE)
                  begin
                     if (shift_reg[7:1] == cur_addr ||
                         (shift_reg[7:1] == smb_pkg::ALERT_RESP_ADDR && alert_act &&
                          shift_reg[0]))
                     begin
                        state_reg  <= smb_pkg::SL_AACK;
                        sda_oe_reg <= 1'b1;
                        rd_reg     <= shift_reg[0];
                        ara_reg    <= shift_reg[7:1] != cur_addr;
                        wbyte_reg  <= 2'h0;
                     end
                     else
                        state_reg <= smb_pkg::SL_IDLE;
                  end
               smb_pkg::SL_AACK, smb_pkg::SL_WACK:
                  if (scl_fall)
                  begin
                     bit_cnt_reg <= 4'h0;
                     if (rd_reg)
                     begin
                        state_reg  <= smb_pkg::SL_RTX;
                        shift_reg  <= rd_data;
                        sda_oe_reg <= !rd_data[7];
                     end
                     else
                     begin
                        state_reg  <= smb_pkg::SL_WRX;
                        sda_oe_reg <= 1'b0;
                     end
                  end
               smb_pkg::SL_WRX:
                  if (scl_rise)
                  begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_reg == smb_pkg::BITS_PER_BYTE)
                  begin
                     if (wbyte_reg == 2'h0)
                        ptr_reg <= shift_reg;
                     else if (wbyte_reg == 2'h1 && shift_reg != 8'h00 &&
                              ptr_reg == smb_pkg::CFG1_ADDR)
                        cfg1_reg <= shift_reg;
                     else if (wbyte_reg == 2'h1 && ptr_reg == smb_pkg::CFG1_ADDR)
                        cfg1_reg <= shift_reg;
                     if (wbyte_reg != 2'h2)
                        wbyte_reg <= wbyte_reg + 2'h1;
                     // acknowledge only the two supported bytes
                     sda_oe_reg <= wbyte_reg != 2'h2;
                     state_reg  <= smb_pkg::SL_WACK;
                  end
               smb_pkg::SL_RTX:
                  if (scl_fall)
                  begin
                     if (bit_cnt_reg == smb_pkg::BITS_PER_BYTE - 4'h1)
                     begin
                        state_reg  <= smb_pkg::SL_RACK;
                        sda_oe_reg <= 1'b0;
                     end
                     else
                     begin
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg  <= !shift_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               smb_pkg::SL_RACK:
                  if (scl_rise)
                     state_reg <= sda_s ? smb_pkg::SL_IDLE : smb_pkg::SL_WACK;
               default:
                  state_reg <= smb_pkg::SL_IDLE;
            endcase
      end
   // data register file written by the second byte
   always_ff @(posedge mclk_i)
      if (ce_i && !start_det && !stop_det && state_reg == smb_pkg::SL_WRX && scl_fall &&
          bit_cnt_reg == smb_pkg::BITS_PER_BYTE && wbyte_reg == 2'h1)
         regs_mem[ptr_reg] <= shift_reg;
   assign bus.sda_s_o  = 1'b0;
   assign bus.sda_s_oe = sda_oe_reg;
   assign pointer_o    = ptr_reg;
   assign cfg1_o       = cfg1_reg;
endmodule : smb_slave
`default_nettype wire

// >>> testbench/smb_assertions.sv
// bus-level assertions for the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smb_assertions (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe
);
   localparam int LOW_MIN = 120;
   logic        scl_q_reg;
   logic        sda_q_reg;
   logic        drove_reg;
   logic [7:0]  rise_cnt_reg;
   logic [9:0]  low_cnt_reg;
   logic [12:0] drv_cnt_reg;
   wire         start = scl && scl_q_reg && !sda && sda_q_reg;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_q_reg    <= 1'b1;
         sda_q_reg    <= 1'b1;
         drove_reg    <= 1'b0;
         rise_cnt_reg <= 8'h00;
         low_cnt_reg  <= 10'h000;
         drv_cnt_reg  <= 13'h0000;
      end
      else
      begin
         scl_q_reg    <= scl;
         sda_q_reg    <= sda;
         drove_reg    <= !start && (drove_reg || sda_s_oe);
         rise_cnt_reg <= start ? 8'h00 : rise_cnt_reg + 8'(scl && !scl_q_reg);
         low_cnt_reg  <= scl ? 10'h000 : low_cnt_reg + 10'(low_cnt_reg != 10'h3ff);
         drv_cnt_reg  <= sda_s_oe ? drv_cnt_reg + 13'h0001 : 13'h0000;
      end
   end
   // ---------------------------------------------------------------
   // wire checks
   // ---------------------------------------------------------------
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   idle_lines_a: assert property ($fell(rst_i) |-> scl && sda)
      else $error("lines not idle after reset");
   sda_on_low_a: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl))
      else $error("slave moved sda while scl high");
   no_slave_cond_a: assert property (scl && $past(scl) && $changed(sda) |-> !sda_s_oe)
      else $error("slave made a start or stop");
   start_clk_a: assert property (start |-> ##[1:300] !scl)
      else $error("no clock after start");
   addr_quiet_a: assert property (rise_cnt_reg < 8'h08 |-> !sda_s_oe)
      else $error("slave drove during address bits");
   addr_ack_a: assert property ($rose(sda_s_oe) && !drove_reg |-> rise_cnt_reg == 8'h08)
      else $error("first slave drive not at ninth clock");
   ack_span_a: assert property ($rose(sda_s_oe) |-> sda_s_oe throughout ##[1:600] $rose(scl))
      else $error("slave drive not held over clock");
   slave_release_a: assert property (drv_cnt_reg < 13'h12c0)
      else $error("slave held sda too long");
   scl_low_min_a: assert property ($rose(scl) |-> low_cnt_reg >= LOW_MIN)
      else $error("scl low phase too short");
   cover property (start);
   cover property ($rose(sda_s_oe) && !drove_reg);
   cover property (scl && scl_q_reg && sda && !sda_q_reg);
endmodule : smb_assertions
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {
      logic [6:0] addr;
      logic       rd;
      logic       rs;
      logic [7:0] b0;
      logic [7:0] b1;
      logic [1:0] nb;
      logic [1:0] sel;
      logic       e_nack;
      logic [7:0] e_dat;
      logic [7:0] e_ptr;
      logic [7:0] e_cfg;
   } smb_row_t;
   localparam logic [6:0] HI  = smb_pkg::ADDR_PIN_HIGH;
   localparam logic [7:0] CFG = smb_pkg::CFG1_ADDR;
   localparam logic [1:0] PH  = smb_pkg::SEL_HIGH;
   localparam logic [1:0] PL  = smb_pkg::SEL_LOW;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       req_i = 1'b0;
   logic       read_i = 1'b0;
   logic       rstart_i = 1'b0;
   logic       ce_m = 1'b1;
   logic       status_clr_i = 1'b0;
   logic [6:0] dev_addr_i = 7'h00;
   logic [1:0] nbytes_i = 2'h1;
   logic [1:0] addr_sel_i = PH;
   logic [7:0] byte0_i = 8'h00;
   logic [7:0] byte1_i = 8'h00;
   logic [7:0] event_i = 8'h00;
   logic [7:0] event_mask_i = 8'h00;
   logic       busy_o, done_o, nack_o, alert_n_o;
   logic [7:0] rdata_o, status_o, pointer_o, cfg1_o;
   int         failures = 0;
   int         check_count = 0;
   smb_row_t   rows [5];
   smb_if smb_if_inst ();
   smb_master smb_master_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_m),
      .bus(smb_if_inst.master), .req_i(req_i), .dev_addr_i(dev_addr_i), .read_i(read_i),
      .nbytes_i(nbytes_i), .byte0_i(byte0_i), .byte1_i(byte1_i), .rstart_i(rstart_i),
      .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
   smb_slave #(.TIMEOUT_CYC(4000)) smb_slave_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .ce_i(1'b1), .bus(smb_if_inst.slave), .addr_sel_i(addr_sel_i), .event_i(event_i),
      .event_mask_i(event_mask_i), .status_clr_i(status_clr_i), .status_o(status_o),
      .alert_n_o(alert_n_o), .pointer_o(pointer_o), .cfg1_o(cfg1_o));
   smb_assertions smb_assertions_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .scl(smb_if_inst.scl), .sda(smb_if_inst.sda), .sda_s_oe(smb_if_inst.sda_s_oe));
   always #2.5 mclk_i = ~mclk_i;
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic run_op(input smb_row_t r);
      int n;
      {dev_addr_i, read_i, rstart_i, byte0_i, byte1_i} = {r.addr, r.rd, r.rs, r.b0, r.b1};
      nbytes_i = r.nb;
      addr_sel_i = r.sel;
      req_i = 1'b1;
      tick(1);
      req_i = 1'b0;
      check({7'h00, busy_o}, 8'h01);
      for (n = 0; n < 40000 && done_o !== 1'b1; n++)
         tick(1);
      if (n == 40000)
         failures++;
      check({7'h00, nack_o}, {7'h00, r.e_nack});
      if (r.rd)
         check(rdata_o, r.e_dat);
      check(pointer_o, r.e_ptr);
      check(cfg1_o, r.e_cfg);
      tick(1);
   endtask : run_op
   task automatic pulse_ev(input logic [7:0] ev, input logic clr, input logic [7:0] e_st,
                           input logic e_al);
      event_i = ev;
      status_clr_i = clr;
      tick(1);
      event_i = 8'h00;
      status_clr_i = 1'b0;
      tick(1);
      check(status_o, e_st);
      check({7'h00, alert_n_o}, {7'h00, e_al});
   endtask : pulse_ev
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial
   begin
      rows[0] = '{HI, 1'b0, 1'b0, CFG, 8'h08, 2'h2, PH, 1'b0, 8'h00, CFG, 8'h08};
      rows[1] = '{HI, 1'b0, 1'b0, 8'h10, 8'h00, 2'h1, PH, 1'b0, 8'h00, 8'h10, 8'h08};
      rows[2] = '{HI, 1'b1, 1'b1, CFG, 8'h00, 2'h1, PL, 1'b0, 8'h08, CFG, 8'h08};
      rows[3] = '{HI, 1'b1, 1'b0, 8'h00, 8'h00, 2'h1, PL, 1'b0, 8'h08, CFG, 8'h08};
      rows[4] = '{7'h2c, 1'b0, 1'b0, 8'h55, 8'h00, 2'h1, PL, 1'b1, 8'h00, CFG, 8'h08};
      tick(12);
      rst_i = 1'b0;
      tick(1);
      check(pointer_o, 8'h00);
      check({7'h00, alert_n_o}, 8'h01);
      foreach (rows[i])
         run_op(rows[i]);
      event_mask_i = 8'h01;
      pulse_ev(8'h01, 1'b0, 8'h01, 1'b1);
      pulse_ev(8'h02, 1'b0, 8'h03, 1'b0);
      rows[4] = '{smb_pkg::ALERT_RESP_ADDR, 1'b1, 1'b0, 8'h00, 8'h00, 2'h1, PL, 1'b0,
                  {HI, 1'b1}, CFG, 8'h08};
      run_op(rows[4]);
      pulse_ev(8'h04, 1'b1, 8'h04, 1'b0);
      pulse_ev(8'h00, 1'b1, 8'h00, 1'b1);
      rst_i = 1'b1;
      tick(2);
      rst_i = 1'b0;
      tick(1);
      check(cfg1_o, 8'h00);
      check(pointer_o, 8'h00);
      // master frozen mid address byte: slave must time out and nack
      rows[4] = '{HI, 1'b0, 1'b0, 8'h33, 8'h00, 2'h1, PH, 1'b1, 8'h00, 8'h00, 8'h00};
      fork
         run_op(rows[4]);
         begin
            tick(2200);
            ce_m = 1'b0;
            tick(5000);
            ce_m = 1'b1;
         end
      join
      give_verdict();
   end
   // watchdog: a little beyond the expected run of seven bus operations
   initial
   begin
      #450000;
      failures++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
